// ### rtl/pin_filter.v
// three-stage synchroniser followed by a persistence filter
module pin_filter #(
	parameter integer FILT_CYC = 500,
	parameter integer CW = 12
)
(
	// clock and reset
	input wire pclk,
	input wire presetn,
	// pin in, filtered level out
	input wire pin,
	output reg level_r
);
	// sync stages; stage one only feeds stage two
	reg s1_r;
	reg s2_r;
	reg s3_r;
	// persistence counter
	reg [CW-1:0] cnt_r;

	// synchroniser and filter; idle level high (pull-up)
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
			cnt_r <= {CW{1'b0}};
			level_r <= 1'b1;
		end
		else
		begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// restart when stages disagree or level matches
			if (s2_r != s3_r || s3_r == level_r)
				cnt_r <= {CW{1'b0}};
			else if (cnt_r == FILT_CYC[CW-1:0])
			begin
				// persisted past the window; accept
				level_r <= s3_r;
				cnt_r <= {CW{1'b0}};
			end
			else
				cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
		end
	end
endmodule // pin_filter

// ### rtl/sleep_seq.v
// sleep-state power sequencer with apb control and status
//
// Chosen here: the register addresses and the APB interface to the registers.
`include "sleep_seq_regs.vh"
module sleep_seq #(
	parameter integer QUAL_CYC = `QUAL_CYC,
	parameter integer VID_DLY_DEF = `VID_POWER_GOOD_DELAY_CYC,
	parameter integer SLEEP_CYC = `SLEEP_DELAY_CYC,
	parameter integer GLITCH_CYC = `GLITCH_CYC
)
(
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// chipset sleep requests, active low
	input wire suspend_ram_req_n,
	input wire soft_off_req_n,
	// analog comparator flags, high means good / tripped
	input wire standby5_supply_ok,
	input wire main33_supply_ok,
	input wire dual33_rail_ok,
	input wire dual5_rail_ok,
	input wire standby15_rail_ok,
	input wire vid12_rail_ok,
	input wire temp_fault_trip,
	input wire temp_shutdown_trip,
	input wire soft_start_low,
	// power switch and regulator controls
	output reg dual_active_drive_o,
	output reg dual_active_drive_oe,
	output reg dual33_standby_drive,
	output reg dual5_standby_switch,
	output reg vid12_enable,
	output reg standby15_enable,
	output reg vid_power_good,
	output reg fault
);
	// state machine register
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	// shared interval counter (sleep delay and qualification)
	reg [23:0] tmr_r;
	reg [23:0] tmr_nxt;
	// vid good delay counter and programmed delay
	reg [23:0] vid_cnt_r;
	reg [23:0] vid_dly_r;
	// control register, bit 0 selects alternate 5V behaviour
	reg [31:0] ctrl_r;
	// filtered requests
	wire s3_n;
	wire s5_n;
	// synchronised comparator flags (3 stages each)
	reg [8:0] f1_r;
	reg [8:0] f2_r;
	reg [8:0] f3_r;
	// agreed flag level
	reg [8:0] fl_r;
	// combinational decodes
	wire in_active;
	wire in_sleep;
	wire kill;
	wire main_ok;
	wire fault_now;
	// apb strobes
	wire wr_en;
	wire rd_en;

	pin_filter #(.FILT_CYC(GLITCH_CYC), .CW(12)) u_filt_s3
	(
		.pclk(pclk),
		.presetn(presetn),
		.pin(suspend_ram_req_n),
		.level_r(s3_n)
	);
	pin_filter #(.FILT_CYC(GLITCH_CYC), .CW(12)) u_filt_s5
	(
		.pclk(pclk),
		.presetn(presetn),
		.pin(soft_off_req_n),
		.level_r(s5_n)
	);

	// flag synchronisers; a change counts when stage 2 and 3 agree
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			f1_r <= 9'h000;
			f2_r <= 9'h000;
			f3_r <= 9'h000;
			fl_r <= 9'h000;
		end
		else
		begin
			f1_r <= {soft_start_low, temp_shutdown_trip, temp_fault_trip,
				vid12_rail_ok, standby15_rail_ok, dual5_rail_ok, dual33_rail_ok,
				main33_supply_ok, standby5_supply_ok};
			f2_r <= f1_r;
			f3_r <= f2_r;
			// bitwise: only bits where stages agree update
			fl_r <= (fl_r & ~(f2_r ~^ f3_r)) | (f3_r & (f2_r ~^ f3_r));
		end
	end

	// named flag views
	wire sb5_ok = fl_r[0];
	wire m33_ok = fl_r[1];
	wire d33_ok = fl_r[2];
	wire d5_ok = fl_r[3];
	wire sb15_ok = fl_r[4];
	wire vid_ok = fl_r[5];
	wire t_flt = fl_r[6];
	wire t_sd = fl_r[7];
	wire ss_low = fl_r[8];

	assign main_ok = m33_ok;
	assign kill = ss_low | t_sd;
	assign in_active = (state_r == `ST_ACTIVE) || (state_r == `ST_WAIT);
	assign in_sleep = (state_r == `ST_SUSP) || (state_r == `ST_SOFTOFF);

	// next state: decode of the filtered request pair
	always @*
	begin
		state_nxt = state_r;
		tmr_nxt = tmr_r;
		case (state_r)
			`ST_BOOT:
			begin
				tmr_nxt = 24'h000000;
				if (s3_n && s5_n)
					state_nxt = `ST_QUAL;
				else if (!s3_n && s5_n)
					state_nxt = `ST_SUSP;
				else if (!s3_n && !s5_n)
					state_nxt = `ST_SOFTOFF;
			end
			`ST_QUAL:
			begin
				// qualification timer, restarted by bad input
				if (!main_ok)
					tmr_nxt = 24'h000000;
				else if (tmr_r >= QUAL_CYC[23:0] - 24'h000001)
				begin
					state_nxt = `ST_ACTIVE;
					tmr_nxt = 24'h000000;
				end
				else
					tmr_nxt = tmr_r + 24'h000001;
				// request dropped during qualification returns to sleep
				if (!s3_n)
				begin
					state_nxt = s5_n ? `ST_SUSP : `ST_SOFTOFF;
					tmr_nxt = 24'h000000;
				end
			end
			`ST_ACTIVE:
			begin
				// suspend request low starts sleep delay
				tmr_nxt = 24'h000000;
				if (!s3_n)
					state_nxt = `ST_WAIT;
			end
			`ST_WAIT:
			begin
				if (s3_n)
				begin
					state_nxt = `ST_ACTIVE;
					tmr_nxt = 24'h000000;
				end
				else if (tmr_r >= SLEEP_CYC[23:0] - 24'h000001)
				begin
					// soft-off if its request is low
					state_nxt = s5_n ? `ST_SUSP : `ST_SOFTOFF;
					tmr_nxt = 24'h000000;
				end
				else
					tmr_nxt = tmr_r + 24'h000001;
			end
			`ST_SUSP:
			begin
				tmr_nxt = 24'h000000;
				if (s3_n && s5_n)
					state_nxt = `ST_QUAL;
			end
			`ST_SOFTOFF:
			begin
				tmr_nxt = 24'h000000;
				if (s3_n && s5_n)
					state_nxt = `ST_QUAL;
			end
			default:
			begin
				state_nxt = `ST_BOOT;
				tmr_nxt = 24'h000000;
			end
		endcase
	end

	// state held in boot until standby supply valid
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= `ST_BOOT;
			tmr_r <= 24'h000000;
		end
		else if (!sb5_ok)
		begin
			state_r <= `ST_BOOT;
			tmr_r <= 24'h000000;
		end
		else
		begin
			state_r <= state_nxt;
			tmr_r <= tmr_nxt;
		end
	end

	// fault sources: output, input undervoltage, temperature
	// dual 3.3V monitored regardless of state
	assign fault_now = t_flt | t_sd | !d33_ok | !sb15_ok
		| (in_active && !main_ok)
		| (state_r == `ST_ACTIVE && !vid_ok)
		| ((state_r == `ST_ACTIVE || state_r == `ST_SUSP
			|| (state_r == `ST_SOFTOFF && ctrl_r[`CTRL_ALT_BIT])) && !d5_ok);

	// output drives, all registered
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dual_active_drive_o <= 1'b0;
			dual_active_drive_oe <= 1'b1;
			dual33_standby_drive <= 1'b0;
			dual5_standby_switch <= 1'b0;
			vid12_enable <= 1'b0;
			standby15_enable <= 1'b0;
			fault <= 1'b0;
		end
		else
		begin
			// open-collector: only ever pulls low
			dual_active_drive_o <= 1'b0;
			dual_active_drive_oe <= kill || !in_active;
			dual33_standby_drive <= !kill && in_sleep;
			// base: 5V standby in suspend only
			dual5_standby_switch <= !kill && ((state_r == `ST_SUSP)
				|| (state_r == `ST_SOFTOFF && ctrl_r[`CTRL_ALT_BIT]));
			vid12_enable <= !kill && in_active;
			standby15_enable <= !kill && sb5_ok;
			fault <= !ss_low && sb5_ok && fault_now;
		end
	end

	// vid power-good with programmable delay
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			vid_cnt_r <= 24'h000000;
			vid_power_good <= 1'b0;
		end
		else if (!vid_ok || !vid12_enable)
		begin
			vid_cnt_r <= 24'h000000;
			vid_power_good <= 1'b0;
		end
		else if (vid_cnt_r >= vid_dly_r)
			vid_power_good <= 1'b1;
		else
			vid_cnt_r <= vid_cnt_r + 24'h000001;
	end

	// apb: zero wait state, access phase answers
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;

	// register writes
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r <= `CTRL_RESET;
			vid_dly_r <= VID_DLY_DEF[23:0];
		end
		else if (wr_en)
		begin
			if (paddr == `CTRL_OFS)
				ctrl_r <= {31'h00000000, pwdata[`CTRL_ALT_BIT]};
			else if (paddr == `VID_DLY_OFS)
				vid_dly_r <= pwdata[23:0];
		end
	end

	// read data captured in setup so it stands in the access phase
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			// ready and error asserted for the access phase only
			pready <= psel && !penable;
			pslverr <= psel && !penable && paddr != `CTRL_OFS
				&& paddr != `STATUS_OFS && paddr != `VID_DLY_OFS;
			if (rd_en)
			begin
				case (paddr)
					`CTRL_OFS: prdata <= ctrl_r;
					`STATUS_OFS: prdata <= {16'h0000, fault, vid_power_good,
						fl_r[8:0], 2'b00, state_r};
					`VID_DLY_OFS: prdata <= {8'h00, vid_dly_r};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // sleep_seq

// ### rtl/sleep_seq_regs.vh
// timing, state and register constants for the sleep-state power sequencer
`ifndef SLEEP_SEQ_REGS_VH
`define SLEEP_SEQ_REGS_VH
// clock rate in kHz (250 MHz)
`define CLK_KHZ 250000
// nominal times
`define GLITCH_NS 2000
`define SLEEP_DELAY_US 200
`define QUAL_MS 25
`define VID_POWER_GOOD_DELAY_US 1000
// derived cycle counts
`define GLITCH_CYC (`GLITCH_NS * `CLK_KHZ / 1000000)
`define SLEEP_DELAY_CYC (`SLEEP_DELAY_US * `CLK_KHZ / 1000)
`define QUAL_CYC (`QUAL_MS * `CLK_KHZ)
`define VID_POWER_GOOD_DELAY_CYC (`VID_POWER_GOOD_DELAY_US * `CLK_KHZ / 1000)
// apb register offsets
`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004
`define VID_DLY_OFS 12'h008
// control fields
`define CTRL_ALT_BIT 0
`define CTRL_RESET 32'h00000000
// operating state encodings
`define ST_BOOT 3'h0
`define ST_QUAL 3'h1
`define ST_ACTIVE 3'h2
`define ST_WAIT 3'h3
`define ST_SUSP 3'h4
`define ST_SOFTOFF 3'h5
`endif

// ### sim/chipset_model.sv
// chipset model driving the active-low sleep request pins
module chipset_model (
	// clock
	input wire pclk,
	// sleep requests, active low
	output logic suspend_ram_req_n,
	output logic soft_off_req_n
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle level is high, as the pins are pulled up
	initial
	begin
		suspend_ram_req_n = 1'b1;
		soft_off_req_n = 1'b1;
	end

	// new request pair, changed just after an edge
	task request(input logic s3_n, input logic s5_n);
		@(posedge pclk);
		suspend_ram_req_n <= s3_n;
		soft_off_req_n <= s5_n;
	endtask

	// short low pulse on the suspend pin, shorter than the filter
	task glitch(input int n);
		@(posedge pclk);
		suspend_ram_req_n <= 1'b0;
		repeat (n) @(posedge pclk);
		suspend_ram_req_n <= 1'b1;
	endtask
endmodule // chipset_model

// ### sim/sleep_seq_asserts.sv
// port assertions for the sleep-state sequencer
module sleep_seq_asserts (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// comparator flags
	input wire standby5_supply_ok,
	input wire vid12_rail_ok,
	input wire temp_fault_trip,
	input wire temp_shutdown_trip,
	input wire soft_start_low,
	// drives
	input wire dual_active_drive_oe,
	input wire dual33_standby_drive,
	input wire dual5_standby_switch,
	input wire vid12_enable,
	input wire standby15_enable,
	input wire vid_power_good,
	input wire fault
);
	timeunit 1ns;
	timeprecision 1ps;
	// every drive off, open collector pulling low
	wire off = dual_active_drive_oe && !vid12_enable && !dual33_standby_drive
		&& !dual5_standby_switch && !standby15_enable;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_DLA_VID: assert property (dual_active_drive_oe == !vid12_enable)
		else $error("dual-active drive and vid enable disagree");
	AST_SB33: assert property (dual33_standby_drive |-> dual_active_drive_oe)
		else $error("3.3V standby drive outside sleep");
	AST_SB5: assert property (dual5_standby_switch |-> dual_active_drive_oe)
		else $error("5V standby switch outside sleep");
	AST_SSL: assert property (soft_start_low [*8] |-> off && !fault)
		else $error("soft-start low left a drive or fault on");
	AST_TSD: assert property (temp_shutdown_trip [*8] |-> off)
		else $error("shutdown temperature left a drive on");
	AST_PG_LOW: assert property (!vid12_rail_ok [*6] |-> !vid_power_good)
		else $error("vid good high with rail low");
	AST_PG_DLY: assert property ($rose(vid_power_good) |-> $past(vid12_rail_ok, 8))
		else $error("vid good released without delay");
	AST_TFLT: assert property ((standby5_supply_ok && temp_fault_trip && !soft_start_low) [*8]
		|-> fault)
		else $error("temperature fault not reported");
	AST_POR: assert property (!standby5_supply_ok [*8] |-> off && !fault)
		else $error("outputs live without standby supply");

	cover property ($fell(dual_active_drive_oe));
	cover property ($rose(dual5_standby_switch));
	cover property ($rose(fault));
	cover property ($rose(vid_power_good));
endmodule // sleep_seq_asserts

bind sleep_seq sleep_seq_asserts sleep_seq_asserts_inst (
	.pclk(pclk),
	.presetn(presetn),
	.standby5_supply_ok(standby5_supply_ok),
	.vid12_rail_ok(vid12_rail_ok),
	.temp_fault_trip(temp_fault_trip),
	.temp_shutdown_trip(temp_shutdown_trip),
	.soft_start_low(soft_start_low),
	.dual_active_drive_oe(dual_active_drive_oe),
	.dual33_standby_drive(dual33_standby_drive),
	.dual5_standby_switch(dual5_standby_switch),
	.vid12_enable(vid12_enable),
	.standby15_enable(standby15_enable),
	.vid_power_good(vid_power_good),
	.fault(fault)
);

// ### sim/test_sleep_seq.sv
// self-checking bench for the sleep-state sequencer
`include "sleep_seq_regs.vh"
module test_sleep_seq;
	timeunit 1ns;
	timeprecision 1ps;
	// apb side
	logic pclk, presetn, psel, penable, pwrite, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	wire [31:0] prdata;
	wire pready, pslverr, suspend_ram_req_n, soft_off_req_n;
	// comparator flags
	logic standby5_supply_ok, main33_supply_ok, dual33_rail_ok, dual5_rail_ok;
	logic standby15_rail_ok, vid12_rail_ok, temp_fault_trip, temp_shutdown_trip, soft_start_low;
	// drives
	wire dual_active_drive_o, dual_active_drive_oe, dual33_standby_drive, dual5_standby_switch;
	wire vid12_enable, standby15_enable, vid_power_good, fault;
	int errors, cmp_count;

	// short counts keep the run brief
	sleep_seq #(.QUAL_CYC(200), .VID_DLY_DEF(20), .SLEEP_CYC(50), .GLITCH_CYC(10))
		sleep_seq_inst (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.suspend_ram_req_n(suspend_ram_req_n),
		.soft_off_req_n(soft_off_req_n),
		.standby5_supply_ok(standby5_supply_ok),
		.main33_supply_ok(main33_supply_ok),
		.dual33_rail_ok(dual33_rail_ok),
		.dual5_rail_ok(dual5_rail_ok),
		.standby15_rail_ok(standby15_rail_ok),
		.vid12_rail_ok(vid12_rail_ok),
		.temp_fault_trip(temp_fault_trip),
		.temp_shutdown_trip(temp_shutdown_trip),
		.soft_start_low(soft_start_low),
		.dual_active_drive_o(dual_active_drive_o),
		.dual_active_drive_oe(dual_active_drive_oe),
		.dual33_standby_drive(dual33_standby_drive),
		.dual5_standby_switch(dual5_standby_switch),
		.vid12_enable(vid12_enable),
		.standby15_enable(standby15_enable),
		.vid_power_good(vid_power_good),
		.fault(fault)
	);
	chipset_model chipset_model_inst (
		.pclk(pclk),
		.suspend_ram_req_n(suspend_ram_req_n),
		.soft_off_req_n(soft_off_req_n)
	);

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", n, exp, seen);
		end
	endtask

	task print_verdict;
		$display("compares %0d, errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// one apb transfer; answer taken at the rising edge that samples pready high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// request held until the edge where ready is seen
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wt(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task st(input logic [2:0] s);
		apb(1'b0, `STATUS_OFS, 32'h0);
		chk("state", rd[2:0], s);
	endtask

	// order: oe, 3.3V standby, 5V standby, vid enable
	task outs(input logic [3:0] e);
		chk("drives", {dual_active_drive_oe, dual33_standby_drive, dual5_standby_switch,
			vid12_enable}, e);
	endtask

	task t_boot;
		int i;
		for (i = 0; i < 400 && dual_active_drive_oe !== 1'b0; i++)
			@(posedge pclk);
		chk("qual cycles", i >= 200 && i < 230, 1);
		wt(30);
		outs(4'h1);
		chk("dla level", dual_active_drive_o, 0);
		chk("vid good", vid_power_good, 1);
		chk("1.5V enable", standby15_enable, 1);
		st(`ST_ACTIVE);
	endtask

	task t_sleep;
		chipset_model_inst.glitch(5);
		wt(40);
		outs(4'h1);
		chipset_model_inst.request(1'b0, 1'b1);
		wt(30);
		outs(4'h1);
		wt(60);
		st(`ST_SUSP);
		outs(4'hE);
		chipset_model_inst.request(1'b0, 1'b0);
		wt(80);
		st(`ST_SUSP);
		chipset_model_inst.request(1'b1, 1'b1);
		wt(300);
		st(`ST_ACTIVE);
	endtask

	task t_off;
		chipset_model_inst.request(1'b0, 1'b0);
		wt(90);
		st(`ST_SOFTOFF);
		outs(4'hC);
		apb(1'b1, `CTRL_OFS, 32'h1);
		apb(1'b0, `CTRL_OFS, 32'h0);
		chk("alt select", rd, 32'h1);
		wt(2);
		outs(4'hE);
		apb(1'b1, `CTRL_OFS, 32'h0);
		dual33_rail_ok <= 1'b0;
		wt(8);
		chk("fault", fault, 1);
		dual33_rail_ok <= 1'b1;
		wt(8);
		chk("fault", fault, 0);
		chipset_model_inst.request(1'b0, 1'b1);
		wt(90);
		st(`ST_SOFTOFF);
		chipset_model_inst.request(1'b1, 1'b0);
		wt(40);
		st(`ST_SOFTOFF);
		chipset_model_inst.request(1'b1, 1'b1);
		wt(300);
		st(`ST_ACTIVE);
	endtask

	task t_fault;
		vid12_rail_ok <= 1'b0;
		wt(8);
		chk("vid good", vid_power_good, 0);
		chk("fault", fault, 1);
		vid12_rail_ok <= 1'b1;
		wt(10);
		chk("vid good", vid_power_good, 0);
		wt(20);
		chk("vid good", vid_power_good, 1);
		temp_fault_trip <= 1'b1;
		wt(8);
		chk("fault", fault, 1);
		soft_start_low <= 1'b1;
		wt(8);
		chk("fault", fault, 0);
		outs(4'h8);
		soft_start_low <= 1'b0;
		temp_fault_trip <= 1'b0;
		temp_shutdown_trip <= 1'b1;
		wt(8);
		outs(4'h8);
		temp_shutdown_trip <= 1'b0;
		main33_supply_ok <= 1'b0;
		wt(8);
		chk("fault", fault, 1);
		main33_supply_ok <= 1'b1;
		standby5_supply_ok <= 1'b0;
		wt(8);
		st(`ST_BOOT);
		chk("1.5V enable", standby15_enable, 0);
		standby5_supply_ok <= 1'b1;
		wt(300);
		st(`ST_ACTIVE);
		// programmed vid delay of 40 cycles
		apb(1'b1, `VID_DLY_OFS, 32'h28);
		apb(1'b0, `VID_DLY_OFS, 32'h0);
		chk("vid delay", rd, 32'h28);
		vid12_rail_ok <= 1'b0;
		wt(8);
		vid12_rail_ok <= 1'b1;
		wt(30);
		chk("vid good", vid_power_good, 0);
		wt(20);
		chk("vid good", vid_power_good, 1);
		apb(1'b0, 12'h00C, 32'h0);
		chk("slverr", {31'h0, err}, 32'h1);
		chk("unmapped read", rd, 32'h0);
	endtask

	initial
	begin
		errors = 0;
		cmp_count = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{standby5_supply_ok, main33_supply_ok, dual33_rail_ok, dual5_rail_ok} = 4'hF;
		{standby15_rail_ok, vid12_rail_ok} = 2'h3;
		{temp_fault_trip, temp_shutdown_trip, soft_start_low} = 3'h0;
		wt(8);
		presetn <= 1'b1;
		t_boot;
		t_sleep;
		t_off;
		t_fault;
		print_verdict;
	end

	// hang guard, well beyond the expected run
	initial
	begin
		#80000;
		errors++;
		print_verdict;
	end
endmodule // test_sleep_seq
